// File: design/hbi_pkg.sv
`default_nettype none
package hbi_pkg;
	// bus style codes on the external mode pins
	localparam logic [1:0] MODE0 = 2'h0;
	localparam logic [1:0] MODE1 = 2'h1;
	localparam logic [1:0] MODE2 = 2'h2;
	localparam logic [1:0] MODE3 = 2'h3;
	// one clock of 8 ns is one half bus state: h=2n is Tn+1 rising, h=2n+1 its falling
	localparam int CLK_NS = 8;
	typedef logic [3:0] hbi_half_t;
	// slave timing per mode, indexed by mode: strobe sample, data act, host release
	localparam hbi_half_t RD_SAMP [4] = '{4'h1, 4'h3, 4'h4, 4'h2};
	localparam hbi_half_t RD_ACT  [4] = '{4'h4, 4'h6, 4'h7, 4'h5};
	localparam hbi_half_t RD_HOLD [4] = '{4'h6, 4'h7, 4'h8, 4'h8};
	localparam hbi_half_t WR_SAMP [4] = '{4'h1, 4'h4, 4'h5, 4'h4};
	localparam hbi_half_t WR_ACT  [4] = '{4'h4, 4'h5, 4'h7, 4'h5};
	localparam hbi_half_t WR_HOLD [4] = '{4'h7, 4'h9, 4'hb, 4'h9};
	// master cycle: three states with no wait inserted
	localparam hbi_half_t M_STRB  = 4'h1;
	localparam hbi_half_t M_WAIT  = 4'h3;
	localparam hbi_half_t M_LATCH = 4'h4;
	localparam hbi_half_t M_END   = 4'h5;
	// pulled-up level of an undriven data bus
	localparam logic [15:0] DATA_IDLE = 16'hffff;

	// low address bit of the byte that rides the high data lane
	function automatic logic hi_lane_a0(input logic [1:0] m);
		return m == MODE0;
	endfunction : hi_lane_a0

	// active lanes {hi, lo} of an access
	function automatic logic [1:0] lanes(input logic [1:0] m, input logic a0,
		input logic ube_n, input logic uds_n, input logic lds_n);
		if (m == MODE0)
			return {!ube_n, !a0};
		else if (m == MODE1)
			return 2'h1;
		else
			return {!uds_n, !lds_n};
	endfunction : lanes

	// true when a single byte at this address travels on the high lane
	function automatic logic byte_on_hi(input logic [1:0] m, input logic a0);
		return (m != MODE1) && (a0 == hi_lane_a0(m));
	endfunction : byte_on_hi
endpackage : hbi_pkg
`default_nettype wire

// File: design/hbi_if.sv
`default_nettype none
interface hbi_if;
	// host side drives
	logic        h_cs_n, h_as_n, h_rd_n, h_wr_n, h_rw;
	logic        h_ube_n, h_uds_n, h_lds_n;
	logic [15:0] h_addr, h_data;
	logic        h_data_oe, h_wait;
	// device side drives; d_ctl_oe claims address and strobes in master mode
	logic        d_ctl_oe, d_rd_n, d_wr_n, d_rw;
	logic        d_ube_n, d_uds_n, d_lds_n;
	logic [15:0] d_addr, d_data;
	logic        d_data_oe, d_wait, d_wait_oe;
	// resolved wires
	logic        cs_n, as_n, rd_n, wr_n, rw;
	logic        upper_byte_enable_n, upper_byte_strobe_n, lower_byte_strobe_n;
	logic [15:0] addr, data;
	logic        wait_rdy;

	assign cs_n = h_cs_n;
	assign as_n = h_as_n;
	assign rd_n = d_ctl_oe ? d_rd_n : h_rd_n;
	assign wr_n = d_ctl_oe ? d_wr_n : h_wr_n;
	assign rw   = d_ctl_oe ? d_rw : h_rw;
	assign upper_byte_enable_n = d_ctl_oe ? d_ube_n : h_ube_n;
	assign upper_byte_strobe_n = d_ctl_oe ? d_uds_n : h_uds_n;
	assign lower_byte_strobe_n = d_ctl_oe ? d_lds_n : h_lds_n;
	assign addr = d_ctl_oe ? d_addr : h_addr;
	assign data = d_data_oe ? d_data : (h_data_oe ? h_data : hbi_pkg::DATA_IDLE);
	assign wait_rdy = d_wait_oe ? d_wait : h_wait;

	modport dev (
		input  cs_n, as_n, rd_n, wr_n, rw, upper_byte_enable_n,
		input  upper_byte_strobe_n, lower_byte_strobe_n, addr, data, wait_rdy,
		output d_ctl_oe, d_rd_n, d_wr_n, d_rw, d_ube_n, d_uds_n, d_lds_n,
		output d_addr, d_data, d_data_oe, d_wait, d_wait_oe
	);
	modport host (
		input  rd_n, wr_n, rw, upper_byte_enable_n, upper_byte_strobe_n,
		input  lower_byte_strobe_n, addr, data, wait_rdy,
		output h_cs_n, h_as_n, h_rd_n, h_wr_n, h_rw, h_ube_n, h_uds_n, h_lds_n,
		output h_addr, h_data, h_data_oe, h_wait
	);
endinterface : hbi_if
`default_nettype wire

// File: design/hbi_split.sv
`default_nettype none
// sizes the next access of a transfer run on the memory side
module hbi_split #(
	parameter int LEN_W = 16
) (
	input  wire logic             i_wide,
	input  wire logic             i_a0,
	input  wire logic [LEN_W-1:0] i_rem,
	output logic                  o_word,
	output logic [1:0]            o_step
);
	if (LEN_W < 2) begin : g_bad
		$error("hbi_split: LEN_W too small");
	end
	// odd start, a lone last byte or the byte-wide style go as bytes, even pairs on a wide bus as words
	assign o_word = i_wide && !i_a0 && (i_rem > LEN_W'(1));
	assign o_step = o_word ? 2'h2 : 2'h1;
endmodule : hbi_split
`default_nettype wire

// File: design/hbi_dev.sv
`default_nettype none
module hbi_dev #(
	parameter int REG_AW = 8,
	parameter int LEN_W  = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_ce,
	input  wire logic [1:0]       i_mode,
	input  wire logic             i_master,
	input  wire logic             i_xfer_go,
	input  wire logic             i_xfer_write,
	input  wire logic [15:0]      i_xfer_addr,
	input  wire logic [LEN_W-1:0] i_xfer_len,
	output logic                  o_xfer_busy,
	output logic                  o_xfer_done,
	output logic                  o_slv_busy,
	hbi_if.dev                    bus
);
	if (REG_AW < 2 || REG_AW > 8) begin : g_bad
		$error("hbi_dev: REG_AW must be 2..8");
	end

	typedef enum logic [2:0] {ST_IDLE, ST_SLV, ST_END, ST_REL, ST_MPLAN, ST_MCYC} hbi_st_e;

	hbi_st_e           st;
	hbi_pkg::hbi_half_t h;
	logic [7:0]        regs [2**REG_AW];
	logic [REG_AW-1:0] cap_a;
	logic [1:0]        cap_ln;
	logic              cap_ube_n;
	logic              wr_cyc;
	logic [15:0]       ptr;
	logic [LEN_W-1:0]  rem;
	logic [REG_AW-1:0] idx;
	logic              xw, mword;
	logic              sel, strb, isw, wide, word, lane0_hi;
	hbi_pkg::hbi_half_t samp_h, act_h;

	// register byte on a given lane of the captured slave address
	function automatic logic [REG_AW-1:0] lane_addr(input logic [1:0] m,
		input logic [REG_AW-1:0] a, input logic hi);
		if (m == hbi_pkg::MODE1)
			return a;
		else
			return {a[REG_AW-1:1], hi ? hbi_pkg::hi_lane_a0(m) : !hbi_pkg::hi_lane_a0(m)};
	endfunction : lane_addr

	// mode pins read live; changing them mid-cycle is not supported
	assign wide = i_mode != hbi_pkg::MODE1;
	assign sel  = (i_mode[1] == 1'b0) ? !bus.cs_n : (!bus.cs_n && !bus.as_n);
	assign strb = (i_mode[1] == 1'b0) ? (!bus.rd_n || !bus.wr_n)
	              : (!bus.upper_byte_strobe_n || !bus.lower_byte_strobe_n);
	assign isw  = (i_mode[1] == 1'b0) ? !bus.wr_n : !bus.rw;
	// per-mode strobe sample point and data edge
	assign samp_h = wr_cyc ? hbi_pkg::WR_SAMP[i_mode] : hbi_pkg::RD_SAMP[i_mode];
	assign act_h  = wr_cyc ? hbi_pkg::WR_ACT[i_mode] : hbi_pkg::RD_ACT[i_mode];
	assign lane0_hi = hbi_pkg::byte_on_hi(i_mode, ptr[0]);

	hbi_split #(
		.LEN_W (LEN_W)
	) u_split (
		.i_wide (wide),
		.i_a0   (ptr[0]),
		.i_rem  (rem),
		.o_word (word),
		.o_step ()
	);

	// main sequencer: slave cycles, then the transfer engine when in master mode
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st          <= ST_IDLE;
			h           <= 4'h0;
			cap_a       <= '0;
			cap_ln      <= 2'h0;
			cap_ube_n   <= 1'b1;
			wr_cyc      <= 1'b0;
			o_slv_busy  <= 1'b0;
			o_xfer_busy <= 1'b0;
			o_xfer_done <= 1'b0;
			ptr         <= 16'h0000;
			rem         <= '0;
			idx         <= '0;
			xw          <= 1'b0;
			mword       <= 1'b0;
		end else if (i_ce) begin
			o_xfer_done <= 1'b0;
			case (st)
				ST_IDLE: begin
					h <= 4'h1;
					if (i_master && i_xfer_go) begin
						ptr         <= i_xfer_addr;
						rem         <= i_xfer_len;
						xw          <= i_xfer_write;
						idx         <= '0;
						o_xfer_busy <= 1'b1;
						st          <= ST_MPLAN;
					end else if (!i_master && sel && strb) begin
						// the cycle starts with select and strobe both seen
						if (!wide)
							cap_a <= bus.addr[REG_AW-1:0];
						else if (i_mode == hbi_pkg::MODE0)
							cap_a <= bus.addr[REG_AW-1:0];
						else
							cap_a <= {bus.addr[REG_AW-1:1], 1'b0};
						cap_ube_n  <= bus.upper_byte_enable_n;
						wr_cyc     <= isw;
						o_slv_busy <= 1'b1;
						st         <= ST_SLV;
					end
				end
				ST_SLV: begin
					if (h != 4'hf)
						h <= h + 4'h1;
					if (h == samp_h) begin
						cap_ln <= hbi_pkg::lanes(i_mode, cap_a[0], cap_ube_n,
							bus.upper_byte_strobe_n, bus.lower_byte_strobe_n);
						if (!strb)
							st <= ST_END;
					end else if (h > samp_h && !strb) begin
						st <= ST_END;
					end
				end
				ST_END: begin
					st <= ST_REL;
				end
				ST_REL: begin
					// mode 0 may keep select low; the host's idle state separates cycles
					if (i_mode == hbi_pkg::MODE0 || !sel) begin
						o_slv_busy <= 1'b0;
						st         <= ST_IDLE;
					end
				end
				ST_MPLAN: begin
					h <= 4'h0;
					if (rem == '0) begin
						o_xfer_busy <= 1'b0;
						o_xfer_done <= 1'b1;
						st          <= ST_IDLE;
					end else begin
						mword <= word;
						st    <= ST_MCYC;
					end
				end
				ST_MCYC: begin
					// a low wait input stretches the cycle
					if (h != hbi_pkg::M_WAIT || bus.wait_rdy)
						h <= h + 4'h1;
					if (h == hbi_pkg::M_END) begin
						ptr <= ptr + {14'h0000, mword, !mword};
						rem <= rem - LEN_W'({mword, !mword});
						idx <= idx + REG_AW'({mword, !mword});
						st  <= ST_MPLAN;
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// bus pin drive: read data, wait, and master-mode address and strobes
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.d_data    <= 16'h0000;
			bus.d_data_oe <= 1'b0;
			bus.d_wait    <= 1'b1;
			bus.d_wait_oe <= 1'b0;
			bus.d_ctl_oe  <= 1'b0;
			bus.d_addr    <= 16'h0000;
			bus.d_rd_n    <= 1'b1;
			bus.d_wr_n    <= 1'b1;
			bus.d_rw      <= 1'b1;
			bus.d_ube_n   <= 1'b1;
			bus.d_uds_n   <= 1'b1;
			bus.d_lds_n   <= 1'b1;
		end else if (i_ce) begin
			bus.d_wait_oe <= !i_master;
			bus.d_ctl_oe  <= (st == ST_MPLAN) || (st == ST_MCYC);
			if (st == ST_IDLE && !i_master && sel && strb)
				bus.d_wait <= 1'b0;
			if (st == ST_END) begin
				bus.d_wait    <= 1'b1;
				bus.d_data_oe <= 1'b0;
			end
			if (st == ST_SLV && !wr_cyc && h == act_h) begin
				bus.d_data[15:8] <= cap_ln[1] ? regs[lane_addr(i_mode, cap_a, 1'b1)] : 8'h00;
				bus.d_data[7:0]  <= cap_ln[0] ? regs[lane_addr(i_mode, cap_a, 1'b0)] : 8'h00;
				bus.d_data_oe    <= 1'b1;
			end
			if (st == ST_MPLAN && rem != '0) begin
				bus.d_addr  <= ptr;
				bus.d_rw    <= !xw;
				bus.d_ube_n <= !(word || lane0_hi);
				if (word)
					bus.d_data <= lane0_hi ? {regs[idx], regs[idx + REG_AW'(1)]}
						: {regs[idx + REG_AW'(1)], regs[idx]};
				else
					bus.d_data <= {regs[idx], regs[idx]};
			end
			if (st == ST_MCYC && h == hbi_pkg::M_STRB) begin
				bus.d_rd_n    <= xw;
				bus.d_wr_n    <= !xw;
				bus.d_uds_n   <= !(mword || lane0_hi);
				bus.d_lds_n   <= !(mword || !lane0_hi || !wide);
				bus.d_data_oe <= xw;
			end
			if (st == ST_MCYC && h == hbi_pkg::M_END) begin
				bus.d_rd_n    <= 1'b1;
				bus.d_wr_n    <= 1'b1;
				bus.d_uds_n   <= 1'b1;
				bus.d_lds_n   <= 1'b1;
				bus.d_data_oe <= 1'b0;
			end
		end
	end

	// register file: slave stores and master-mode reads from memory
	always_ff @(posedge i_clk) begin
		if (i_ce && st == ST_SLV && wr_cyc && h == act_h) begin
			if (cap_ln[1])
				regs[lane_addr(i_mode, cap_a, 1'b1)] <= bus.data[15:8];
			if (cap_ln[0])
				regs[lane_addr(i_mode, cap_a, 1'b0)] <= bus.data[7:0];
		end else if (i_ce && st == ST_MCYC && !xw && h == hbi_pkg::M_LATCH) begin
			regs[idx] <= lane0_hi ? bus.data[15:8] : bus.data[7:0];
			if (mword)
				regs[idx + REG_AW'(1)] <= lane0_hi ? bus.data[7:0] : bus.data[15:8];
		end
	end
endmodule : hbi_dev
`default_nettype wire

// File: design/hbi_host.sv
`default_nettype none
module hbi_host #(
	parameter int MEM_AW = 8
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic [1:0]  i_mode,
	input  wire logic        i_req,
	input  wire logic        i_write,
	input  wire logic [7:0]  i_addr,
	input  wire logic [1:0]  i_lanes,
	input  wire logic [15:0] i_wdata,
	input  wire logic [3:0]  i_stretch,
	input  wire logic        i_mem_ready,
	output logic [15:0]      o_rdata,
	output logic             o_done,
	output logic             o_idle,
	hbi_if.host              bus
);
	if (MEM_AW < 2 || MEM_AW > 16) begin : g_bad
		$error("hbi_host: MEM_AW must be 2..16");
	end

	typedef enum logic [1:0] {HS_IDLE, HS_STRB, HS_WAIT, HS_GAP} hbi_hst_e;

	hbi_hst_e    st;
	logic [4:0]  h;
	logic        wr;
	logic [4:0]  rel_h;
	logic [7:0]  mem [2**MEM_AW];
	logic [1:0]  mln;
	logic [MEM_AW-1:0] ma_hi, ma_lo;
	logic [15:0] mem_q;
	logic        mem_oe;

	// strobe held through the release point plus any read stretch
	assign rel_h = wr ? {1'b0, hbi_pkg::WR_HOLD[i_mode]}
	               : ({1'b0, hbi_pkg::RD_HOLD[i_mode]} + {1'b0, i_stretch});
	// memory lanes decoded the same way the device drives them
	assign mln   = hbi_pkg::lanes(i_mode, bus.addr[0], bus.upper_byte_enable_n,
	               bus.upper_byte_strobe_n, bus.lower_byte_strobe_n);
	assign ma_hi = {bus.addr[MEM_AW-1:1], hbi_pkg::hi_lane_a0(i_mode)};
	assign ma_lo = (i_mode == hbi_pkg::MODE1) ? bus.addr[MEM_AW-1:0]
	               : {bus.addr[MEM_AW-1:1], !hbi_pkg::hi_lane_a0(i_mode)};

	// slave-cycle sequencer toward the device registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st            <= HS_IDLE;
			h             <= 5'h00;
			wr            <= 1'b0;
			o_rdata       <= 16'h0000;
			o_done        <= 1'b0;
			o_idle        <= 1'b1;
			bus.h_cs_n    <= 1'b1;
			bus.h_as_n    <= 1'b1;
			bus.h_rd_n    <= 1'b1;
			bus.h_wr_n    <= 1'b1;
			bus.h_rw      <= 1'b1;
			bus.h_ube_n   <= 1'b1;
			bus.h_uds_n   <= 1'b1;
			bus.h_lds_n   <= 1'b1;
			bus.h_addr    <= 16'h0000;
			bus.h_data    <= 16'h0000;
			bus.h_data_oe <= 1'b0;
		end else if (i_ce) begin
			o_done <= 1'b0;
			case (st)
				HS_IDLE: begin
					h <= 5'h00;
					// memory answers a device read one clock after its strobe falls
					if (mem_oe)
						bus.h_data <= mem_q;
					bus.h_data_oe <= mem_oe;
					if (i_req) begin
						// select, address, direction and strobe all go out together
						wr            <= i_write;
						o_idle        <= 1'b0;
						bus.h_cs_n    <= 1'b0;
						bus.h_as_n    <= 1'b0;
						bus.h_addr    <= {8'h00, i_addr};
						bus.h_rw      <= !i_write;
						bus.h_ube_n   <= !i_lanes[1];
						bus.h_uds_n   <= !i_lanes[1];
						bus.h_lds_n   <= !i_lanes[0];
						bus.h_rd_n    <= i_write || i_mode[1];
						bus.h_wr_n    <= !i_write || i_mode[1];
						bus.h_data    <= i_wdata;
						bus.h_data_oe <= i_write;
						st            <= HS_STRB;
					end
				end
				HS_STRB: begin
					h <= h + 5'h01;
					if (h == rel_h) begin
						if (!wr)
							o_rdata <= bus.data;
						bus.h_rd_n    <= 1'b1;
						bus.h_wr_n    <= 1'b1;
						bus.h_uds_n   <= 1'b1;
						bus.h_lds_n   <= 1'b1;
						bus.h_data_oe <= 1'b0;
						st            <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					// end of cycle shows as wait going high
					if (bus.wait_rdy) begin
						bus.h_cs_n <= 1'b1;
						bus.h_as_n <= 1'b1;
						st         <= HS_GAP;
					end
				end
				HS_GAP: begin
					// one idle state before the next register cycle
					o_done <= 1'b1;
					o_idle <= 1'b1;
					st     <= HS_IDLE;
				end
				default: st <= HS_IDLE;
			endcase
		end
	end

	// memory side of master-mode cycles run by the device
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.h_wait <= 1'b1;
		end else if (i_ce) begin
			bus.h_wait <= i_mem_ready;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce && !bus.wr_n && st == HS_IDLE) begin
			if (mln[1])
				mem[ma_hi] <= bus.data[15:8];
			if (mln[0])
				mem[ma_lo] <= bus.data[7:0];
		end
	end

	// memory read data; the host's own strobes stay idle while the device is master
	assign mem_q  = {mem[ma_hi], mem[ma_lo]};
	assign mem_oe = !bus.rd_n && st == HS_IDLE;
endmodule : hbi_host
`default_nettype wire

// File: tb/hbi_asserts.sv
`default_nettype none
// watches the joined interface; h counts half states of a slave access from its first cycle
module hbi_asserts (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [1:0]  i_mode,
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        rw,
	input  wire logic        upper_byte_enable_n,
	input  wire logic        upper_byte_strobe_n,
	input  wire logic        lower_byte_strobe_n,
	input  wire logic [15:0] addr,
	input  wire logic        wait_rdy,
	input  wire logic        d_ctl_oe,
	input  wire logic        d_data_oe,
	input  wire logic        d_wait,
	input  wire logic        d_wait_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       rdq, wrq, strb, mstrb, in_cyc, is_rd;
	logic [4:0] h, rd_act;

	// in modes 2 and 3 the byte strobes, qualified by direction, are the strobes
	assign rdq    = i_mode[1] ? (rw && !(upper_byte_strobe_n && lower_byte_strobe_n)) : !rd_n;
	assign wrq    = i_mode[1] ? (!rw && !(upper_byte_strobe_n && lower_byte_strobe_n)) : !wr_n;
	assign strb   = rdq || wrq;
	assign mstrb  = d_ctl_oe && !(rd_n && wr_n);
	assign rd_act = {1'b0, hbi_pkg::RD_ACT[i_mode]};

	// saturating count, so a stretched read cannot wrap back into the early window
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			in_cyc <= 1'b0;
			h      <= 5'h0;
			is_rd  <= 1'b0;
		end else if (!in_cyc) begin
			in_cyc <= !cs_n && strb && !d_ctl_oe;
			h      <= 5'h1;
			is_rd  <= rdq;
		end else if (cs_n) begin
			in_cyc <= 1'b0;
		end else if (h != 5'h1f) begin
			h <= h + 5'h1;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_data_early: assert property (in_cyc && h <= rd_act |-> !d_data_oe)
		else $error("read data driven before its half state");
	chk_data_on: assert property (in_cyc && is_rd && h == rd_act + 5'h1 |-> d_data_oe)
		else $error("read data missing at its half state");
	chk_data_hold: assert property (in_cyc && is_rd && h > rd_act + 5'h1 && strb |-> d_data_oe)
		else $error("read data dropped while strobe low");
	chk_write_quiet: assert property (in_cyc && !is_rd |-> !d_data_oe)
		else $error("device drove data in a write");
	chk_wait_low: assert property (in_cyc && h == 5'h1 |-> !d_wait [*4])
		else $error("wait not low early in access");
	chk_release_wait: assert property (in_cyc && $fell(strb) |-> ##2 (d_wait && !d_data_oe))
		else $error("wait or data wrong after strobe release");
	chk_idle_gap: assert property (!d_ctl_oe && i_mode == hbi_pkg::MODE0 && $fell(strb) |-> !strb [*3])
		else $error("no idle state between accesses");
	chk_wait_input: assert property (d_ctl_oe [*2] |-> !d_wait_oe)
		else $error("wait driven while device owns the bus");
	chk_mstrobe_len: assert property ($rose(mstrb) |-> mstrb [*4])
		else $error("master strobe too short");
	chk_lane_mode0: assert property (mstrb && i_mode == hbi_pkg::MODE0 |-> !(upper_byte_enable_n && addr[0]))
		else $error("odd byte off the high lane");
	chk_word_even: assert property (mstrb && i_mode[1] && !upper_byte_strobe_n && !lower_byte_strobe_n |-> !addr[0])
		else $error("word access at odd address");
	chk_odd_lane: assert property (mstrb && i_mode[1] && addr[0] |-> upper_byte_strobe_n)
		else $error("odd byte on the high lane");

	cov_long_read: cover property (in_cyc && is_rd && h == 5'd12);
	cov_stall: cover property (mstrb && !wait_rdy);
	cov_odd_byte: cover property (mstrb && addr[0]);
endmodule : hbi_asserts
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
// host end and device end face each other; bench drives both user sides
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, master = 1'b0, go = 1'b0, req = 1'b0, wr = 1'b0;
	logic        mem_ready = 1'b1, ms_q = 1'b1, mpend = 1'b0, xwr = 1'b1;
	logic        xbusy, xdone, sbusy, done, idle, wseen;
	logic [1:0]  mode = 2'h0, lanes = 2'h0;
	logic [3:0]  stretch = 4'h0;
	logic [7:0]  haddr = 8'h0;
	logic [15:0] xaddr = 16'h0, xlen = 16'h0, wdata = 16'h0;
	logic [15:0] rdata;
	logic [16:0] macc[$];
	int          err_count = 0, total_checks = 0;

	hbi_if i_hbi_if ();
	hbi_dev i_hbi_dev (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_mode(mode),
		.i_master(master), .i_xfer_go(go), .i_xfer_write(xwr), .i_xfer_addr(xaddr),
		.i_xfer_len(xlen), .o_xfer_busy(xbusy), .o_xfer_done(xdone), .o_slv_busy(sbusy),
		.bus(i_hbi_if));
	hbi_host i_hbi_host (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_mode(mode), .i_req(req),
		.i_write(wr), .i_addr(haddr), .i_lanes(lanes), .i_wdata(wdata), .i_stretch(stretch),
		.i_mem_ready(mem_ready), .o_rdata(rdata), .o_done(done), .o_idle(idle),
		.bus(i_hbi_if));
	hbi_asserts i_hbi_asserts (.i_clk(clk), .i_rst_n(rst_n), .i_mode(mode),
		.cs_n(i_hbi_if.cs_n), .rd_n(i_hbi_if.rd_n), .wr_n(i_hbi_if.wr_n), .rw(i_hbi_if.rw),
		.upper_byte_enable_n(i_hbi_if.upper_byte_enable_n),
		.upper_byte_strobe_n(i_hbi_if.upper_byte_strobe_n),
		.lower_byte_strobe_n(i_hbi_if.lower_byte_strobe_n), .addr(i_hbi_if.addr),
		.wait_rdy(i_hbi_if.wait_rdy), .d_ctl_oe(i_hbi_if.d_ctl_oe),
		.d_data_oe(i_hbi_if.d_data_oe), .d_wait(i_hbi_if.d_wait), .d_wait_oe(i_hbi_if.d_wait_oe));

	// 125 MHz
	always #4 clk = ~clk;

	// word access as seen on the wire, from the lane pins of the current style
	assign wseen = (mode == hbi_pkg::MODE0) ?
		!(i_hbi_if.upper_byte_enable_n || i_hbi_if.addr[0]) :
		mode[1] && !(i_hbi_if.upper_byte_strobe_n || i_hbi_if.lower_byte_strobe_n);

	// log each master access two clocks after its strobe falls, once lanes have settled
	always @(posedge clk) begin
		ms_q  <= i_hbi_if.rd_n & i_hbi_if.wr_n;
		mpend <= i_hbi_if.d_ctl_oe && ms_q && !(i_hbi_if.rd_n & i_hbi_if.wr_n);
		if (mpend)
			macc.push_back({i_hbi_if.addr, wseen});
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	// one register access; request pulsed for a single clock so it is taken once
	task automatic host_op(input logic w, input logic [7:0] a, input logic [1:0] ln,
		input logic [15:0] d, input logic [3:0] st);
		int k;
		@(negedge clk);
		req = 1'b1;
		wr = w;
		haddr = a;
		lanes = ln;
		wdata = d;
		stretch = st;
		@(negedge clk);
		req = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 200) begin
			@(negedge clk);
			k++;
		end
		chk({14'h0, k < 200, idle}, 16'h3);
		chk({15'h0, sbusy}, 16'h0);
	endtask : host_op

	// one transfer run; memory optionally stalls the first access
	task automatic xfer(input logic [1:0] m, input logic [15:0] a, input logic [15:0] n,
		input logic st, input logic w);
		logic [15:0] ea, left;
		logic        ew;
		int          k;
		macc.delete();
		mode = m;
		master = 1'b1;
		xaddr = a;
		xlen = n;
		mem_ready = !st;
		xwr = w;
		repeat (2) @(negedge clk);
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		chk({15'h0, xbusy}, 16'h1);
		k = 0;
		while (xdone !== 1'b1 && k < 500) begin
			@(negedge clk);
			k++;
			if (k == 12)
				mem_ready = 1'b1;
		end
		chk({14'h0, k < 500, xbusy}, 16'h2);
		master = 1'b0;
		mem_ready = 1'b1;
		ea = a;
		left = n;
		while (left != 16'h0) begin
			ew = (m != hbi_pkg::MODE1) && !ea[0] && left >= 16'h2;
			chk(macc.size() > 0 ? macc[0][16:1] : 16'hxxxx, ea);
			chk(macc.size() > 0 ? {15'h0, macc[0][0]} : 16'hxxxx, {15'h0, ew});
			if (macc.size() > 0)
				void'(macc.pop_front());
			ea = ea + (ew ? 16'h2 : 16'h1);
			left = left - (ew ? 16'h2 : 16'h1);
		end
		chk(16'(macc.size()), 16'h0);
		repeat (2) @(negedge clk);
	endtask : xfer

	// word write then reads; odd byte on the high lane, stretched
	task automatic t_mode0;
		mode = hbi_pkg::MODE0;
		host_op(1'b1, 8'h08, 2'h3, 16'h1234, 4'h0);
		host_op(1'b0, 8'h08, 2'h3, 16'h0000, 4'h0);
		chk(rdata, 16'h1234);
		host_op(1'b0, 8'h09, 2'h2, 16'h0000, 4'h3);
		chk({8'h0, rdata[15:8]}, 16'h0012);
	endtask : t_mode0

	// byte-wide style sees every address on the low lane
	task automatic t_mode1;
		mode = hbi_pkg::MODE1;
		host_op(1'b1, 8'h21, 2'h1, 16'h005a, 4'h0);
		host_op(1'b0, 8'h21, 2'h1, 16'h0000, 4'h0);
		chk({8'h0, rdata[7:0]}, 16'h005a);
		host_op(1'b0, 8'h09, 2'h1, 16'h0000, 4'h2);
		chk({8'h0, rdata[7:0]}, 16'h0012);
	endtask : t_mode1

	// even byte rides the high lane, so mode 0 data comes back swapped
	task automatic t_mode23;
		for (int m = 2; m < 4; m++) begin
			mode = 2'(m);
			host_op(1'b0, 8'h08, 2'h3, 16'h0000, 4'h0);
			chk(rdata, 16'h3412);
			host_op(1'b1, 8'(2 * m + 6), 2'h3, 16'habcd, 4'h0);
			host_op(1'b0, 8'(2 * m + 6), 2'h3, 16'h0000, 4'h0);
			chk(rdata, 16'habcd);
		end
		mode = hbi_pkg::MODE0;
		host_op(1'b0, 8'h0c, 2'h3, 16'h0000, 4'h0);
		chk(rdata, 16'hcdab);
	endtask : t_mode23

	// runs from odd starts in every style and an even start in mode 2, two of them stalled
	task automatic t_master;
		xfer(hbi_pkg::MODE0, 16'h0011, 16'h4, 1'b1, 1'b1);
		xfer(hbi_pkg::MODE2, 16'h0020, 16'h2, 1'b0, 1'b1);
		xfer(hbi_pkg::MODE3, 16'h0031, 16'h2, 1'b0, 1'b1);
		xfer(hbi_pkg::MODE2, 16'h0035, 16'h5, 1'b1, 1'b1);
		xfer(hbi_pkg::MODE1, 16'h0041, 16'h3, 1'b0, 1'b1);
	endtask : t_master

	// registers out to memory, then an odd-start stalled run back into the registers
	task automatic t_mread;
		mode = hbi_pkg::MODE0;
		host_op(1'b1, 8'h00, 2'h3, 16'h2211, 4'h0);
		host_op(1'b1, 8'h02, 2'h3, 16'h4433, 4'h0);
		xfer(hbi_pkg::MODE0, 16'h0050, 16'h4, 1'b0, 1'b1);
		xfer(hbi_pkg::MODE0, 16'h0051, 16'h3, 1'b1, 1'b0);
		host_op(1'b0, 8'h00, 2'h3, 16'h0000, 4'h0);
		chk(rdata, 16'h3322);
		host_op(1'b0, 8'h02, 2'h3, 16'h0000, 4'h0);
		chk(rdata, 16'h4444);
	endtask : t_mread

	// main sequence
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		t_mode0();
		t_mode1();
		t_mode23();
		t_master();
		t_mread();
		close_out();
	end

	// hang guard, far beyond the several hundred clocks the run needs
	initial begin
		#200000;
		err_count++;
		close_out();
	end
endmodule : testbench
`default_nettype wire
